//--- logic/boot_select_pkg.sv
// constants and carrier types for the selective boot path selector
// assumes a single 20 MHz core clock and a word-wide flash read port
package boot_select_pkg;
    localparam logic [1:0] strap_alternate = 2'h1;
    localparam logic [1:0] strap_standard = 2'h2;
    localparam logic [19:0] addr_user_op0 = 20'h00000;
    localparam logic [19:0] addr_user_op1 = 20'h01ffc;
    localparam logic [19:0] addr_user_ref = 20'h01ffe;
    localparam logic [19:0] addr_alt_op0 = 20'h90000;
    localparam logic [19:0] addr_alt_op1 = 20'h91ffc;
    localparam logic [19:0] addr_alt_ref = 20'h91ffe;
    localparam logic [19:0] addr_select = 20'h01ffc;
    localparam logic [15:0] word_zeros = 16'h0000;
    localparam logic [15:0] word_ones = 16'hffff;
    localparam logic [7:0] sel_uart_only = 8'h01;
    localparam logic [7:0] sel_can_only = 8'h02;
    localparam logic [7:0] sel_both = 8'h03;
    localparam int sel_uart_bit = 0;
    localparam int sel_can_bit = 1;

    typedef enum logic [2:0]
    {
        path_none,
        path_normal,
        path_standard_loader,
        path_user_code,
        path_alternate_code,
        path_selective,
        path_parking
    } boot_path_t;

    typedef struct packed
    {
        logic watch_uart;
        logic watch_can;
        logic uart_start;
        logic can_start;
    } channel_state_t;
endpackage

//--- logic/flash_word_reader.sv
// one-word flash reader: issues a read and returns the word two cycles after start
// assumes flash answers with read_data valid in the cycle after read_strobe
`timescale 1ns/1ns
module flash_word_reader
    import boot_select_pkg::*;
(
    input wire logic clock,              // core clock
    input wire logic sys_rst,            // synchronous reset
    input wire logic start,              // request pulse
    input wire logic [19:0] address,     // word address
    output logic read_strobe,            // flash read pulse
    output logic [19:0] read_address,    // flash address
    input wire logic [15:0] read_data,   // flash data
    output logic done,                   // word ready pulse
    output logic [15:0] word             // captured word
);
    logic pending;
    logic next_pending;
    logic next_done;
    logic [15:0] next_word;
    logic [19:0] next_read_address;

    assign read_strobe = start;

    always_comb
    begin
        next_pending = start;
        next_done = pending;
        next_word = pending ? read_data : word;
        next_read_address = start ? address : read_address;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pending <= 1'b0;
            done <= 1'b0;
            word <= 16'h0000;
            read_address <= 20'h00000;
        end
        else
        begin
            pending <= next_pending;
            done <= next_done;
            word <= next_word;
            read_address <= next_read_address;
        end
    end

    a_done_after_start: assert property (@(posedge clock) disable iff (sys_rst)
        start |-> ##2 done)
        else $error("flash word not returned two cycles after start");
endmodule

//--- logic/selective_boot_selector.sv
// boot path selector: strap latch, signature checks and selective boot decode
// assumes reset_input_pin and receive lines are asynchronous pins
`timescale 1ns/1ns
module selective_boot_selector
    import boot_select_pkg::*;
(
    input wire logic clock,                           // core clock
    input wire logic sys_rst,                         // synchronous reset
    input wire logic reset_input_pin,                 // external reset pin, low active level
    input wire logic [1:0] reset_config_port_low,     // strap pins 5..4
    input wire logic uart_receive_input,              // uart rx pin
    input wire logic can_receive_input,               // can rx pin
    output logic flash_read,                          // flash read pulse
    output logic [19:0] flash_address,                // flash word address
    input wire logic [15:0] flash_data,               // flash word
    output logic alternate_boot_flag,                 // alternate mode strapped
    output boot_path_t boot_path,                     // chosen path
    output channel_state_t channels,                  // watch enables and starts
    output logic boot_done                            // decision made
);
    typedef enum
    {
        ph_wait_pin,
        ph_decide,
        ph_fetch,
        ph_await,
        ph_check,
        ph_select,
        ph_watch,
        ph_final
    } state_t;
    logic [1:0] pin_sync;
    logic [1:0] uart_sync;
    logic [1:0] can_sync;
    logic pin_prev;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    state_t state;
    state_t next_state;
    logic [1:0] strap;
    logic [1:0] next_strap;
    logic [2:0] step;
    logic [2:0] next_step;
    logic [15:0] op0;
    logic [15:0] next_op0;
    logic [15:0] op1;
    logic [15:0] next_op1;
    logic alt_set;
    logic next_alt_set;
    boot_path_t next_boot_path;
    channel_state_t next_channels;
    logic next_boot_done;
    logic next_alternate_boot_flag;
    logic rd_start;
    logic [19:0] rd_addr;
    logic rd_done;
    logic [15:0] rd_word;
    logic pin_rise;
    function automatic logic sig_ok(input logic [15:0] a, input logic [15:0] b, input logic [15:0] r);
        logic [15:0] s;
        s = a + b;
        return {s[15:8], ~s[7:0]} == r;
    endfunction
    function automatic logic [19:0] step_addr(input logic alt, input logic [2:0] k);
        logic [19:0] a;
        a = addr_user_op0;
        case (k)
            3'h0: a = alt ? addr_alt_op0 : addr_user_op0;
            3'h1: a = alt ? addr_alt_op1 : addr_user_op1;
            3'h2: a = alt ? addr_alt_ref : addr_user_ref;
            default: a = addr_select;
        endcase
        return a;
    endfunction
    flash_word_reader reader
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(rd_start),
        .address(rd_addr),
        .read_strobe(flash_read),
        .read_address(flash_address),
        .read_data(flash_data),
        .done(rd_done),
        .word(rd_word)
    );

    // two flops on every pin before use; strap sampled with the same depth
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pin_sync <= 2'h0;
            uart_sync <= 2'h3;
            can_sync <= 2'h3;
            strap_s1 <= 2'h0;
            strap_s2 <= 2'h0;
            pin_prev <= 1'b0;
        end
        else
        begin
            pin_sync <= {pin_sync[0], reset_input_pin};
            uart_sync <= {uart_sync[0], uart_receive_input};
            can_sync <= {can_sync[0], can_receive_input};
            strap_s1 <= reset_config_port_low;
            strap_s2 <= strap_s1;
            pin_prev <= pin_sync[1];
        end
    end
    assign pin_rise = pin_sync[1] & ~pin_prev;
    assign rd_start = (state == ph_fetch);
    assign rd_addr = step_addr(alt_set, step);

    always_comb
    begin
        next_state = state;
        next_strap = strap;
        next_step = step;
        next_op0 = op0;
        next_op1 = op1;
        next_alt_set = alt_set;
        next_boot_path = boot_path;
        next_channels = channels;
        next_boot_done = boot_done;
        next_alternate_boot_flag = alternate_boot_flag;
        case (state)
            ph_wait_pin:
                if (pin_rise)
                begin
                    next_strap = strap_s2;
                    next_state = ph_decide;
                end
            ph_decide:
            begin
                next_alternate_boot_flag = (strap == strap_alternate);
                if (strap == strap_alternate)
                begin
                    next_alt_set = 1'b0;
                    next_step = 3'h0;
                    next_state = ph_fetch;
                end
                else
                begin
                    next_boot_path = (strap == strap_standard) ? path_standard_loader : path_normal;
                    next_state = ph_final;
                end
            end
            ph_fetch:
                next_state = ph_await;
            ph_await:
                if (rd_done)
                begin
                    next_state = ph_fetch;
                    if (step == 3'h0)
                        next_op0 = rd_word;
                    if (step == 3'h1)
                        next_op1 = rd_word;
                    next_step = step + 3'h1;
                    if (step == 3'h2)
                        next_state = ph_check;
                    if (step == 3'h3)
                        next_state = ph_select;
                end
            ph_check:
                if (sig_ok(op0, op1, rd_word))
                begin
                    next_boot_path = alt_set ? path_alternate_code : path_user_code;
                    next_state = ph_final;
                end
                else if (!alt_set)
                begin
                    next_alt_set = 1'b1;
                    next_step = 3'h0;
                    next_state = ph_fetch;
                end
                else
                begin
                    next_step = 3'h3;
                    next_state = ph_fetch;
                end
            ph_select:
            begin
                if (rd_word == word_zeros || rd_word == word_ones)
                begin
                    next_boot_path = path_standard_loader;
                    next_state = ph_final;
                end
                else if (rd_word[7:0] == sel_both || rd_word[7:0] == sel_uart_only
                    || rd_word[7:0] == sel_can_only)
                begin
                    next_channels.watch_uart = rd_word[sel_uart_bit];
                    next_channels.watch_can = rd_word[sel_can_bit];
                    next_boot_path = path_selective;
                    next_state = ph_watch;
                end
                else
                begin
                    next_boot_path = path_parking;
                    next_state = ph_final;
                end
                next_boot_done = 1'b1;
            end
            ph_watch:
            begin
                // a low level on an enabled line counts as a start condition
                if (channels.watch_uart && !uart_sync[1])
                    next_channels.uart_start = 1'b1;
                if (channels.watch_can && !can_sync[1])
                    next_channels.can_start = 1'b1;
            end
            ph_final:
                next_boot_done = 1'b1;
            default:
                next_state = ph_wait_pin;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state <= ph_wait_pin;
            strap <= 2'h0;
            step <= 3'h0;
            op0 <= 16'h0000;
            op1 <= 16'h0000;
            alt_set <= 1'b0;
            boot_path <= path_none;
            channels <= '0;
            boot_done <= 1'b0;
            alternate_boot_flag <= 1'b0;
        end
        else
        begin
            state <= next_state;
            strap <= next_strap;
            step <= next_step;
            op0 <= next_op0;
            op1 <= next_op1;
            alt_set <= next_alt_set;
            boot_path <= next_boot_path;
            channels <= next_channels;
            boot_done <= next_boot_done;
            alternate_boot_flag <= next_alternate_boot_flag;
        end
    end
    a_park_holds: assert property (@(posedge clock) disable iff (sys_rst)
        boot_path == path_parking |=> boot_path == path_parking)
        else $error("parking path left without reset");
    a_zero_word_std: assert property (@(posedge clock) disable iff (sys_rst)
        state == ph_select && rd_word == word_zeros |=> boot_path == path_standard_loader)
        else $error("zero selection word did not pick standard loader");
    a_ones_word_std: assert property (@(posedge clock) disable iff (sys_rst)
        state == ph_select && rd_word == word_ones |=> boot_path == path_standard_loader)
        else $error("ones selection word did not pick standard loader");
    a_bad_low_park: assert property (@(posedge clock) disable iff (sys_rst)
        state == ph_select && rd_word != word_zeros && rd_word != word_ones && rd_word[7:0] > sel_both
        |=> boot_path == path_parking)
        else $error("invalid selection did not park");
    a_uart_only_sel: assert property (@(posedge clock) disable iff (sys_rst)
        state == ph_select && rd_word[7:0] == sel_uart_only
        |=> channels.watch_uart && !channels.watch_can)
        else $error("uart-only selection wrong");
    a_can_only_sel: assert property (@(posedge clock) disable iff (sys_rst)
        state == ph_select && rd_word[7:0] == sel_can_only && rd_word != word_ones
        |=> !channels.watch_uart && channels.watch_can)
        else $error("can-only selection wrong");
    a_both_sel: assert property (@(posedge clock) disable iff (sys_rst)
        state == ph_select && rd_word[7:0] == sel_both && rd_word != word_ones
        |=> channels.watch_uart && channels.watch_can)
        else $error("both-channel selection wrong");
    a_no_uart_start: assert property (@(posedge clock) disable iff (sys_rst)
        !channels.watch_uart |-> !channels.uart_start)
        else $error("uart start seen while unwatched");
    a_no_can_start: assert property (@(posedge clock) disable iff (sys_rst)
        !channels.watch_can |-> !channels.can_start)
        else $error("can start seen while unwatched");
    a_strap_gate: assert property (@(posedge clock) disable iff (sys_rst)
        state == ph_decide && strap != strap_alternate |=> !alternate_boot_flag ##1 state == ph_final)
        else $error("non-alternate strap entered alternate path");
    a_select_read: assert property (@(posedge clock) disable iff (sys_rst)
        state == ph_check && alt_set && !sig_ok(op0, op1, rd_word)
        |=> flash_read && rd_addr == addr_select)
        else $error("selection word not reread after failed signatures");
endmodule

//--- testbench/flash_boot_words.sv
// flash model holding the six boot words that the selector reads
// assumes words are read one cycle after the read pulse, as the selector expects
`timescale 1ns/1ns
module flash_boot_words
    import boot_select_pkg::*;
(
    input wire logic clock,                   // core clock
    input wire logic sys_rst,                 // synchronous reset
    input wire logic flash_read,              // read pulse from selector
    input wire logic [19:0] flash_address,    // word address from selector
    input wire logic [5:0][15:0] flash_words, // user op0,op1,ref then alternate op0,op1,ref
    output logic [15:0] flash_data            // word returned
);
    logic answering;
    logic [15:0] last;

    // selection word shares its location with user operand1
    function automatic logic [15:0] lookup(input logic [19:0] addr);
        case (addr)
            addr_user_op0: return flash_words[0];
            addr_user_op1: return flash_words[1];
            addr_user_ref: return flash_words[2];
            addr_alt_op0: return flash_words[3];
            addr_alt_op1: return flash_words[4];
            addr_alt_ref: return flash_words[5];
            default: return ~last;
        endcase
    endfunction

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            answering <= 1'b0;
            last <= 16'h0000;
        end
        else
        begin
            answering <= flash_read;
            if (answering)
                last <= flash_data;
        end
    end

    // outside the answer cycle show the inverse so stale data cannot pass
    assign flash_data = answering ? lookup(flash_address) : ~last;
endmodule

//--- testbench/tb_selective_boot_selector.sv
// self-checking bench for the boot path selector
// assumes the flash model above and receive lines idle high
`timescale 1ns/1ns
module tb_selective_boot_selector;
    import boot_select_pkg::*;
    logic clock, sys_rst, reset_input_pin, uart_receive_input, can_receive_input;
    logic [1:0] reset_config_port_low;
    logic flash_read, alternate_boot_flag, boot_done;
    logic [19:0] flash_address;
    logic [15:0] flash_data;
    logic [5:0][15:0] flash_words;
    boot_path_t boot_path;
    channel_state_t channels;
    int failures, tests_run;
    logic [15:0] sel_tab [8] = '{16'h0000, 16'hffff, 16'h1203, 16'hab01, 16'h0002, 16'h0004, 16'hff00, 16'h00ff};

    selective_boot_selector dut_u (.clock(clock), .sys_rst(sys_rst), .reset_input_pin(reset_input_pin),
        .reset_config_port_low(reset_config_port_low), .uart_receive_input(uart_receive_input),
        .can_receive_input(can_receive_input), .flash_read(flash_read), .flash_address(flash_address),
        .flash_data(flash_data), .alternate_boot_flag(alternate_boot_flag), .boot_path(boot_path),
        .channels(channels), .boot_done(boot_done));
    flash_boot_words flash_u (.clock(clock), .sys_rst(sys_rst), .flash_read(flash_read),
        .flash_address(flash_address), .flash_words(flash_words), .flash_data(flash_data));

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] sig(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] s;
        s = a + b;
        return {s[15:8], ~s[7:0]};
    endfunction

    // pin low during reset, then a rising edge latches the strap
    task automatic boot(input logic [1:0] strap, input logic [5:0][15:0] w);
        int n;
        flash_words = w;
        sys_rst = 1'b1;
        reset_input_pin = 1'b0;
        reset_config_port_low = strap;
        uart_receive_input = 1'b1;
        can_receive_input = 1'b1;
        repeat (2) @(negedge clock);
        check({13'h0, boot_path}, {13'h0, path_none}, "path in reset");
        sys_rst = 1'b0;
        repeat (3) @(negedge clock);
        reset_input_pin = 1'b1;
        n = 0;
        while (boot_done !== 1'b1 && n < 200)
        begin
            @(negedge clock);
            n++;
        end
        if (n >= 200)
        begin
            failures++;
            $display("wrong value at %0t: no boot decision", $time);
            give_verdict();
        end
        repeat (2) @(negedge clock);
    endtask

    // both lines pulled low; only watched ones may record a start
    task automatic pull_rx(input logic exp_uart, input logic exp_can);
        uart_receive_input = 1'b0;
        can_receive_input = 1'b0;
        repeat (6) @(negedge clock);
        uart_receive_input = 1'b1;
        can_receive_input = 1'b1;
        repeat (2) @(negedge clock);
        check({15'h0, channels.uart_start}, {15'h0, exp_uart}, "uart start");
        check({15'h0, channels.can_start}, {15'h0, exp_can}, "can start");
    endtask

    initial
    begin
        logic [15:0] s;
        logic [7:0] lo;
        boot_path_t exp_path;
        failures = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        reset_input_pin = 1'b0;
        reset_config_port_low = 2'h3;
        uart_receive_input = 1'b1;
        can_receive_input = 1'b1;
        flash_words = '0;
        repeat (5) @(negedge clock);
        boot(2'h3, '0);
        check({13'h0, boot_path}, {13'h0, path_normal}, "strap 11 path");
        check({15'h0, alternate_boot_flag}, 16'h0000, "flag strap 11");
        boot(2'h0, '0);
        check({13'h0, boot_path}, {13'h0, path_normal}, "strap 00 path");
        boot(strap_standard, '0);
        check({13'h0, boot_path}, {13'h0, path_standard_loader}, "strap 10 path");
        check({15'h0, alternate_boot_flag}, 16'h0000, "flag strap 10");
        boot(strap_alternate, {16'h0, 16'h0, 16'h0, sig(16'h1234, 16'h0203), 16'h0203, 16'h1234});
        check({13'h0, boot_path}, {13'h0, path_user_code}, "user signature");
        check({15'h0, alternate_boot_flag}, 16'h0001, "flag strap 01");
        boot(strap_alternate, {sig(16'h4321, 16'h00ff), 16'h00ff, 16'h4321, 16'h0001, 16'h0203, 16'h1234});
        check({13'h0, boot_path}, {13'h0, path_alternate_code}, "alternate signature");
        // selection words carry nonzero upper bits in selective cases (1203, ab01) as well as in parking ones
        for (int i = 0; i < 8; i++)
        begin
            s = sel_tab[i];
            lo = s[7:0];
            if (s == 16'h0000 || s == 16'hffff)
                exp_path = path_standard_loader;
            else if (lo == sel_uart_only || lo == sel_can_only || lo == sel_both)
                exp_path = path_selective;
            else
                exp_path = path_parking;
            boot(strap_alternate, {sig(16'h4321, 16'h0101) ^ 16'h0100, 16'h0101, 16'h4321,
                sig(16'h1234, s) ^ 16'h0001, s, 16'h1234});
            check({13'h0, boot_path}, {13'h0, exp_path}, "selection path");
            check({15'h0, channels.watch_uart}, {15'h0, exp_path == path_selective && lo[0]}, "uart watch");
            check({15'h0, channels.watch_can}, {15'h0, exp_path == path_selective && lo[1]}, "can watch");
            pull_rx(exp_path == path_selective && lo[0], exp_path == path_selective && lo[1]);
        end
        // parked device ignores a new pin edge and other straps
        reset_config_port_low = 2'h3;
        reset_input_pin = 1'b0;
        repeat (4) @(negedge clock);
        reset_input_pin = 1'b1;
        repeat (10) @(negedge clock);
        check({13'h0, boot_path}, {13'h0, path_parking}, "parking held");
        check({15'h0, boot_done}, 16'h0001, "done held");
        give_verdict();
    end
endmodule
